// >>> inc/timer_pkg.sv
package timer_pkg;
	// byte-wide i/o addresses
	localparam logic [7:0] ADDR_COUNT0_LO = 8'h0c;
	localparam logic [7:0] ADDR_COUNT0_HI = 8'h0d;
	localparam logic [7:0] ADDR_RELOAD0_LO = 8'h0e;
	localparam logic [7:0] ADDR_RELOAD0_HI = 8'h0f;
	localparam logic [7:0] ADDR_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_COUNT1_LO = 8'h14;
	localparam logic [7:0] ADDR_COUNT1_HI = 8'h15;
	localparam logic [7:0] ADDR_RELOAD1_LO = 8'h16;
	localparam logic [7:0] ADDR_RELOAD1_HI = 8'h17;

	localparam int COUNT_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [15:0] COUNT_RESET = 16'hffff;
	localparam logic [15:0] COUNT_LAST = 16'h0001;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

	// control/status field positions
	localparam int BIT_FLAG1 = 7;
	localparam int BIT_FLAG0 = 6;
	localparam int BIT_IE1 = 5;
	localparam int BIT_IE0 = 4;
	localparam int BIT_SEL_HI = 3;
	localparam int BIT_SEL_LO = 2;
	localparam int BIT_EN1 = 1;
	localparam int BIT_EN0 = 0;

	// count tick is the system clock divided by this
	localparam int PRESCALE_DIV = 20;
	localparam int PRESCALE_W = 5;
	localparam logic [4:0] PRESCALE_LAST = 5'(PRESCALE_DIV - 1);
	localparam logic [4:0] PRESCALE_ZERO = 5'h00;
	localparam logic [4:0] PRESCALE_ONE = 5'h01;

	typedef enum logic [1:0]
	{
		PIN_ADDRESS = 2'b00,
		PIN_TOGGLE = 2'b01,
		PIN_LOW = 2'b10,
		PIN_HIGH = 2'b11
	} pin_mode_e;
endpackage

// >>> src/down_count_channel.sv
module down_count_channel
#(
	parameter int W = timer_pkg::COUNT_W
)
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic tick,
	input wire logic count_en,
	input wire logic wr_lo,
	input wire logic wr_hi,
	input wire logic [7:0] wdata,
	input wire logic [W-1:0] reload,
	output logic [W-1:0] count,
	output logic zero
);
	logic [W-1:0] count_ff;
	logic [W-1:0] nxt_count;

	// a written zero also reloads on the next tick instead of wrapping
	function automatic logic at_last(input logic [W-1:0] v);
		at_last = (v <= W'(timer_pkg::COUNT_LAST));
	endfunction

	assign zero = tick && count_en && !wr_lo && !wr_hi && at_last(count_ff);
	assign count = count_ff;

	always_comb
	begin
		nxt_count = count_ff;
		if (wr_lo || wr_hi)
		begin
			// software writes win over the tick; meant for a stopped counter
			if (wr_lo)
				nxt_count[timer_pkg::BYTE_W-1:0] = wdata;
			if (wr_hi)
				nxt_count[W-1:timer_pkg::BYTE_W] = wdata[W-timer_pkg::BYTE_W-1:0];
		end
		else if (tick && count_en)
		begin
			if (at_last(count_ff))
				nxt_count = reload; // see [R2]
			else
				nxt_count = count_ff - W'(1); // see [R9]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			count_ff <= W'(timer_pkg::COUNT_RESET); // see [R11]
		else
			count_ff <= nxt_count;
	end

	a_reload_zero: assert property (@(posedge clk) disable iff (!rst_b)
		zero |=> count_ff == $past(reload)) // see [R2]
		else $error("counter did not reload at zero");

	a_stop_hold: assert property (@(posedge clk) disable iff (!rst_b)
		(!count_en && !wr_lo && !wr_hi) |=> count_ff == $past(count_ff)) // see [R9]
		else $error("stopped counter changed");

	a_count_step: assert property (@(posedge clk) disable iff (!rst_b)
		(tick && count_en && !wr_lo && !wr_hi && !at_last(count_ff))
		|=> count_ff == $past(count_ff) - W'(1)) // see [R3]
		else $error("counter did not decrement by one");
endmodule

// >>> src/dual_reload_down_timer.sv
// Functional notes
// [R1] two 16-bit reload values, byte accessible
// [R2] counter reloads automatically on reaching zero
// [R3] count tick is clock divided by twenty
// [R4] zero sets channel flag in bits 7-6
// [R5] flag clears after control read, count read
// [R6] flag and enable raise interrupt request
// [R7] select field picks address, toggle, low, high
// [R8] select 00 drives address line on pin
// [R9] enable bit runs counter, clear stops it
// [R10] reset clears both count enables
// [R11] reset: control zero, counts/reloads all ones
// [R12] low then high read gives consistent value
// [R13] low read latches high byte for later
// [R14] software avoids reload between reload byte writes
// [R15] software updates reload before next zero
// [R16] pin level follows select before first zero
// [R17] flags read-only, other control bits writable
// [R18] pin action on same tick as reload
module dual_reload_down_timer
(
	input wire logic MCLK,
	input wire logic RST_B,
	input wire logic [7:0] IO_ADDR,
	input wire logic [7:0] IO_WDATA,
	input wire logic IO_WR,
	input wire logic IO_RD,
	output logic [7:0] IO_RDATA,
	input wire logic UPPER_ADDRESS_LINE,
	output logic TIMER_WAVE_PIN,
	output logic IRQ
);
	localparam int CW = timer_pkg::COUNT_W;
	localparam int BW = timer_pkg::BYTE_W;

	logic [timer_pkg::PRESCALE_W-1:0] prescale_ff;
	logic tick;

	logic [1:0] ie_ff;
	logic [1:0] en_ff;
	timer_pkg::pin_mode_e sel_ff;
	logic [1:0] flag_ff;
	logic [1:0] armed_ff;
	logic [1:0][CW-1:0] reload_ff;
	logic [1:0][BW-1:0] hold_ff;
	logic [1:0] hold_vld_ff;
	logic wave_ff;
	logic pin_ff;
	logic [7:0] rdata_ff;

	logic [1:0][CW-1:0] count;
	logic [1:0] zero;
	logic [1:0] wr_cnt_lo;
	logic [1:0] wr_cnt_hi;
	logic [1:0] wr_rld_lo;
	logic [1:0] wr_rld_hi;
	logic [1:0] rd_cnt_lo;
	logic [1:0] rd_cnt_hi;
	logic [1:0] rd_cnt;
	logic wr_ctrl;
	logic rd_ctrl;
	logic [7:0] ctrl_view;
	logic [7:0] nxt_rdata;
	timer_pkg::pin_mode_e wsel;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		hit = (a == r);
	endfunction

	// one decoded strobe per register; reads and writes act in their cycle
	assign wr_ctrl = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_CONTROL);
	assign rd_ctrl = IO_RD && hit(IO_ADDR, timer_pkg::ADDR_CONTROL);
	assign wr_cnt_lo[0] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_COUNT0_LO);
	assign wr_cnt_hi[0] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_COUNT0_HI);
	assign wr_cnt_lo[1] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_COUNT1_LO);
	assign wr_cnt_hi[1] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_COUNT1_HI);
	assign wr_rld_lo[0] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_RELOAD0_LO);
	assign wr_rld_hi[0] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_RELOAD0_HI);
	assign wr_rld_lo[1] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_RELOAD1_LO);
	assign wr_rld_hi[1] = IO_WR && hit(IO_ADDR, timer_pkg::ADDR_RELOAD1_HI);
	assign rd_cnt_lo[0] = IO_RD && hit(IO_ADDR, timer_pkg::ADDR_COUNT0_LO);
	assign rd_cnt_hi[0] = IO_RD && hit(IO_ADDR, timer_pkg::ADDR_COUNT0_HI);
	assign rd_cnt_lo[1] = IO_RD && hit(IO_ADDR, timer_pkg::ADDR_COUNT1_LO);
	assign rd_cnt_hi[1] = IO_RD && hit(IO_ADDR, timer_pkg::ADDR_COUNT1_HI);
	assign rd_cnt = rd_cnt_lo | rd_cnt_hi;
	assign wsel = timer_pkg::pin_mode_e'(
		IO_WDATA[timer_pkg::BIT_SEL_HI:timer_pkg::BIT_SEL_LO]);

	// shared prescaler; both channels tick together
	assign tick = (prescale_ff == timer_pkg::PRESCALE_LAST); // see [R3]

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			prescale_ff <= timer_pkg::PRESCALE_ZERO;
		else if (tick)
			prescale_ff <= timer_pkg::PRESCALE_ZERO; // see [R3]
		else
			prescale_ff <= prescale_ff + timer_pkg::PRESCALE_ONE;
	end

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : g_chan
			down_count_channel #(.W(CW)) u_chan
			(
				.clk(MCLK),
				.rst_b(RST_B),
				.tick(tick),
				.count_en(en_ff[ch]),
				.wr_lo(wr_cnt_lo[ch]),
				.wr_hi(wr_cnt_hi[ch]),
				.wdata(IO_WDATA),
				.reload(reload_ff[ch]),
				.count(count[ch]),
				.zero(zero[ch])
			);
		end
	endgenerate

	// writable control fields; the two flag bits ignore writes
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			ie_ff <= timer_pkg::CONTROL_RESET[timer_pkg::BIT_IE1:timer_pkg::BIT_IE0];
			en_ff <= timer_pkg::CONTROL_RESET[
				timer_pkg::BIT_EN1:timer_pkg::BIT_EN0]; // see [R10]
			sel_ff <= timer_pkg::PIN_ADDRESS; // see [R11]
		end
		else if (wr_ctrl)
		begin
			ie_ff <= IO_WDATA[timer_pkg::BIT_IE1:timer_pkg::BIT_IE0]; // see [R17]
			en_ff <= IO_WDATA[timer_pkg::BIT_EN1:timer_pkg::BIT_EN0]; // see [R9]
			sel_ff <= wsel; // see [R7]
		end
	end

	// reload values, one byte at a time
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			reload_ff[0] <= timer_pkg::COUNT_RESET; // see [R11]
			reload_ff[1] <= timer_pkg::COUNT_RESET;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (wr_rld_lo[i])
					reload_ff[i][BW-1:0] <= IO_WDATA; // see [R1]
				if (wr_rld_hi[i])
					reload_ff[i][CW-1:BW] <= IO_WDATA; // see [R1]
			end
		end
	end

	// a control read arms the clear; the next count read of that channel
	// performs it. a zero in the same cycle wins, so no event is lost.
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			flag_ff <= 2'b00; // see [R5]
			armed_ff <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (zero[i])
					flag_ff[i] <= 1'b1; // see [R4]
				else if (armed_ff[i] && rd_cnt[i])
					flag_ff[i] <= 1'b0; // see [R5]
				if (rd_ctrl)
					armed_ff[i] <= 1'b1;
				else if (rd_cnt[i])
					armed_ff[i] <= 1'b0;
			end
		end
	end

	// high byte latched by a low read so a running count reads consistently
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
		begin
			hold_ff <= '0;
			hold_vld_ff <= 2'b00;
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (rd_cnt_lo[i])
				begin
					hold_ff[i] <= count[i][CW-1:BW]; // see [R13]
					hold_vld_ff[i] <= 1'b1;
				end
				else if (rd_cnt_hi[i])
					hold_vld_ff[i] <= 1'b0; // see [R12]
			end
		end
	end

	assign ctrl_view = {flag_ff[1], flag_ff[0], ie_ff[1], ie_ff[0],
		sel_ff, en_ff[1], en_ff[0]};

	// a lone high read (no prior low read) returns the live high byte
	always_comb
	begin
		nxt_rdata = timer_pkg::RDATA_UNMAPPED;
		case (IO_ADDR)
			timer_pkg::ADDR_CONTROL:
				nxt_rdata = ctrl_view;
			timer_pkg::ADDR_COUNT0_LO:
				nxt_rdata = count[0][BW-1:0];
			timer_pkg::ADDR_COUNT0_HI:
				nxt_rdata = hold_vld_ff[0] ? hold_ff[0] : count[0][CW-1:BW]; // see [R13]
			timer_pkg::ADDR_COUNT1_LO:
				nxt_rdata = count[1][BW-1:0];
			timer_pkg::ADDR_COUNT1_HI:
				nxt_rdata = hold_vld_ff[1] ? hold_ff[1] : count[1][CW-1:BW]; // see [R13]
			timer_pkg::ADDR_RELOAD0_LO:
				nxt_rdata = reload_ff[0][BW-1:0];
			timer_pkg::ADDR_RELOAD0_HI:
				nxt_rdata = reload_ff[0][CW-1:BW];
			timer_pkg::ADDR_RELOAD1_LO:
				nxt_rdata = reload_ff[1][BW-1:0];
			timer_pkg::ADDR_RELOAD1_HI:
				nxt_rdata = reload_ff[1][CW-1:BW];
			default:
				nxt_rdata = timer_pkg::RDATA_UNMAPPED;
		endcase
	end

	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			rdata_ff <= timer_pkg::RDATA_UNMAPPED;
		else if (IO_RD)
			rdata_ff <= nxt_rdata;
	end

	assign IO_RDATA = rdata_ff;

	// waveform level: a control write selecting low or high sets the starting level, channel 1
	// zero applies the action. the write wins if both land together.
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			wave_ff <= 1'b0;
		else if (wr_ctrl)
		begin
			case (wsel)
				timer_pkg::PIN_LOW: wave_ff <= 1'b0; // see [R16]
				timer_pkg::PIN_HIGH: wave_ff <= 1'b1; // see [R16]
				default: wave_ff <= wave_ff;
			endcase
		end
		else if (zero[1])
		begin
			case (sel_ff)
				timer_pkg::PIN_TOGGLE: wave_ff <= !wave_ff; // see [R7] [R18]
				timer_pkg::PIN_LOW: wave_ff <= 1'b0; // see [R7] [R18]
				timer_pkg::PIN_HIGH: wave_ff <= 1'b1; // see [R7] [R18]
				default: wave_ff <= wave_ff;
			endcase
		end
	end

	// registered pin costs one clock of address delay but keeps it glitch free
	always_ff @(posedge MCLK)
	begin
		if (!RST_B)
			pin_ff <= 1'b0;
		else if (sel_ff == timer_pkg::PIN_ADDRESS)
			pin_ff <= UPPER_ADDRESS_LINE; // see [R8]
		else
			pin_ff <= wave_ff;
	end

	assign TIMER_WAVE_PIN = pin_ff;
	assign IRQ = |(flag_ff & ie_ff); // see [R6]

	a_tick_period: assert property (@(posedge MCLK) disable iff (!RST_B)
		tick |=> !tick [*8] ##12 tick) // see [R3]
		else $error("count tick period is not twenty clocks");

	a_flag_set: assert property (@(posedge MCLK) disable iff (!RST_B)
		zero[0] |=> flag_ff[0] && (IRQ || !ie_ff[0])) // see [R4]
		else $error("zero did not set channel 0 flag");

	a_flag_clear: assert property (@(posedge MCLK) disable iff (!RST_B)
		(rd_ctrl ##1 (rd_cnt[1] && !zero[1] && !rd_ctrl)) |=> !flag_ff[1]) // see [R5]
		else $error("flag 1 not cleared by control then count read");

	a_flag_keep: assert property (@(posedge MCLK) disable iff (!RST_B)
		(flag_ff[0] && !(armed_ff[0] && rd_cnt[0])) |=> flag_ff[0]) // see [R5] [R17]
		else $error("flag 0 lost without clearing sequence");

	a_irq_level: assert property (@(posedge MCLK) disable iff (!RST_B)
		(flag_ff[1] && ie_ff[1]) || (flag_ff[0] && ie_ff[0]) |-> IRQ) // see [R6]
		else $error("interrupt request missing");

	a_pin_addr: assert property (@(posedge MCLK) disable iff (!RST_B)
		sel_ff == timer_pkg::PIN_ADDRESS
		|=> TIMER_WAVE_PIN == $past(UPPER_ADDRESS_LINE)) // see [R8]
		else $error("pin does not follow address line");

	a_pin_toggle: assert property (@(posedge MCLK) disable iff (!RST_B)
		(zero[1] && !wr_ctrl && sel_ff == timer_pkg::PIN_TOGGLE)
		|=> wave_ff != $past(wave_ff) ##1 TIMER_WAVE_PIN == $past(wave_ff)) // see [R18]
		else $error("pin did not toggle at channel 1 zero");

	a_pin_start: assert property (@(posedge MCLK) disable iff (!RST_B)
		(wr_ctrl && wsel == timer_pkg::PIN_HIGH) |=> ##1 TIMER_WAVE_PIN) // see [R16]
		else $error("forced high level not applied");

	a_hold_read: assert property (@(posedge MCLK) disable iff (!RST_B)
		(rd_cnt_lo[0] ##1 (rd_cnt_hi[0] && !rd_cnt_lo[0]))
		|=> IO_RDATA == $past(count[0][CW-1:BW], 2)) // see [R12] [R13]
		else $error("high byte read not from latched value");

	a_reset_vals: assert property (@(posedge MCLK)
		!RST_B |=> count[0] == timer_pkg::COUNT_RESET
		&& reload_ff[1] == timer_pkg::COUNT_RESET && en_ff == 2'b00
		&& flag_ff == 2'b00) // see [R10] [R11]
		else $error("reset values wrong");
endmodule

// >>> dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LIMIT = 5000;
	localparam logic [7:0] CTL = timer_pkg::ADDR_CONTROL;
	logic MCLK = 1'b0;
	logic RST_B = 1'b0;
	logic [7:0] IO_ADDR = 8'h00;
	logic [7:0] IO_WDATA = 8'h00;
	logic IO_WR = 1'b0;
	logic IO_RD = 1'b0;
	logic [7:0] IO_RDATA;
	logic UPPER_ADDRESS_LINE = 1'b0;
	logic TIMER_WAVE_PIN;
	logic IRQ;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int seed = 54;
	logic [7:0] rd;
	logic [7:0] lo;
	logic [7:0] ctl;
	logic [15:0] v16;
	logic [15:0] exp16;
	logic b;
	logic [7:0] cnt_a[2] = '{timer_pkg::ADDR_COUNT0_LO, timer_pkg::ADDR_COUNT1_LO};
	logic [7:0] rl_a[2] = '{timer_pkg::ADDR_RELOAD0_LO, timer_pkg::ADDR_RELOAD1_LO};

	dual_reload_down_timer dut
	(
		.MCLK(MCLK),
		.RST_B(RST_B),
		.IO_ADDR(IO_ADDR),
		.IO_WDATA(IO_WDATA),
		.IO_WR(IO_WR),
		.IO_RD(IO_RD),
		.IO_RDATA(IO_RDATA),
		.UPPER_ADDRESS_LINE(UPPER_ADDRESS_LINE),
		.TIMER_WAVE_PIN(TIMER_WAVE_PIN),
		.IRQ(IRQ)
	);

	initial
	begin
		forever #10 MCLK = ~MCLK;
	end

	function automatic logic [15:0] ctrl_exp(logic f1, logic f0, logic [7:0] c);
		return {8'h00, f1, f0, c[5:0]};
	endfunction

	function automatic logic [15:0] after_ticks(logic [15:0] v, int n);
		return v - 16'(n);
	endfunction

	task automatic conclude();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	always @(posedge MCLK)
	begin
		cyc <= cyc + 1;
		if (cyc == LIMIT)
		begin
			fails++;
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic test_done(input string name);
		$display("test %s done", name);
	endtask

	// strobes are one-cycle pulses; the design acts once per high cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge MCLK);
		IO_ADDR <= a;
		IO_WDATA <= d;
		IO_WR <= 1'b1;
		@(posedge MCLK);
		IO_WR <= 1'b0;
		#1;
	endtask

	task automatic rdb(input logic [7:0] a);
		@(posedge MCLK);
		IO_ADDR <= a;
		IO_RD <= 1'b1;
		@(posedge MCLK);
		IO_RD <= 1'b0;
		#1 rd = IO_RDATA;
	endtask

	task automatic wr16(input logic [7:0] a, input logic [15:0] v);
		wr(a, v[7:0]);
		wr(a + 8'h01, v[15:8]);
	endtask

	// two reads in back-to-back cycles; the first byte lands in v16[7:0]
	task automatic rd2(input logic [7:0] a, input logic [7:0] a2);
		@(posedge MCLK);
		IO_ADDR <= a;
		IO_RD <= 1'b1;
		@(posedge MCLK);
		IO_ADDR <= a2;
		#1 v16[7:0] = IO_RDATA;
		@(posedge MCLK);
		IO_RD <= 1'b0;
		#1 v16[15:8] = IO_RDATA;
	endtask

	task automatic rd16(input logic [7:0] a);
		rd2(a, a + 8'h01);
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (IRQ !== 1'b1 && n < 200)
		begin
			@(posedge MCLK);
			n++;
		end
		check(16'(IRQ), 16'h0001);
	endtask

	initial
	begin
		repeat (12) @(posedge MCLK);
		RST_B <= 1'b1;
		// idle long enough to prove nothing counts before enable
		repeat (50) @(posedge MCLK);
		rdb(CTL);
		check(16'(rd), 16'(timer_pkg::CONTROL_RESET));
		for (int c = 0; c < 2; c++)
		begin
			rd16(cnt_a[c]);
			check(v16, 16'hffff);
			rd16(rl_a[c]);
			check(v16, 16'hffff);
		end
		test_done("reset");
		for (int i = 0; i < 6; i++)
		begin
			exp16 = 16'($random(seed));
			wr16(rl_a[i % 2], exp16);
			rd16(rl_a[i % 2]);
			check(v16, exp16);
		end
		test_done("reload");
		wr(CTL, 8'hfc);
		rdb(CTL);
		check(16'(rd), 16'h003c);
		check(16'(IRQ), 16'h0000);
		check(16'(TIMER_WAVE_PIN), 16'h0001);
		wr(CTL, 8'h08);
		repeat (2) @(posedge MCLK);
		#1;
		check(16'(TIMER_WAVE_PIN), 16'h0000);
		wr(CTL, 8'h00);
		for (int i = 0; i < 8; i++)
		begin
			b = (i == 0) ? 1'b1 : 1'($random(seed));
			@(posedge MCLK);
			UPPER_ADDRESS_LINE <= b;
			repeat (2) @(posedge MCLK);
			#1;
			check(16'(TIMER_WAVE_PIN), 16'(b));
		end
		test_done("control");
		// enable spans exactly 200 clocks, so exactly ten ticks land
		wr16(cnt_a[1], 16'h1000);
		wr(CTL, 8'h02);
		repeat (198) @(posedge MCLK);
		wr(CTL, 8'h00);
		rd16(cnt_a[1]);
		check(v16, after_ticks(16'h1000, 10));
		repeat (100) @(posedge MCLK);
		rd16(cnt_a[1]);
		check(v16, after_ticks(16'h1000, 10));
		test_done("rate");
		// live high byte drops to 00 meanwhile; the held copy must not
		wr16(cnt_a[1], 16'h0101);
		wr(CTL, 8'h02);
		rdb(cnt_a[1]);
		lo = rd;
		repeat (60) @(posedge MCLK);
		rdb(cnt_a[1] + 8'h01);
		check(16'(rd), 16'h0001);
		check(16'(lo <= 8'h01), 16'h0001);
		wr(CTL, 8'h00);
		test_done("latch");
		for (int c = 0; c < 2; c++)
		begin
			exp16 = 16'h0003 + 16'(c);
			wr16(rl_a[c], exp16);
			wr16(cnt_a[c], 16'h0002);
			// this read also drops a clear left armed by older control reads
			rd16(cnt_a[c]);
			check(v16, 16'h0002);
			ctl = (c == 1) ? 8'h26 : 8'h11;
			wr(CTL, ctl);
			wait_irq();
			repeat (3) @(posedge MCLK);
			#1;
			if (c == 1)
				check(16'(TIMER_WAVE_PIN), 16'h0001);
			rd16(cnt_a[c]);
			check(v16, exp16);
			check(16'(IRQ), 16'h0001);
			// control read and count read in back-to-back cycles
			rd2(CTL, cnt_a[c]);
			check(16'(v16[7:0]), ctrl_exp(c == 1, c == 0, ctl));
			check(16'(IRQ), 16'h0000);
			wait_irq();
			repeat (3) @(posedge MCLK);
			#1;
			if (c == 1)
				check(16'(TIMER_WAVE_PIN), 16'h0000);
			wr(CTL, ctl & 8'hce);
			check(16'(IRQ), 16'h0000);
			rdb(CTL);
			check(16'(rd), ctrl_exp(c == 1, c == 0, ctl & 8'hce));
			rdb(cnt_a[c]);
			wr(CTL, 8'h00);
		end
		test_done("zero");
		conclude();
	end
endmodule
